// ---- acc_ctrl.sv ----
// Converter control: registers over AXI4-Lite, start logic, timing and result lock
`timescale 1ns/1ps
// Function
// - Reference and channel selections take effect only while enabled.
// - 10-bit result in two bytes, right aligned unless left align is set.
// - Reading low byte blocks result updates from the next cycle until high byte read.
// - Conversion finishing while blocked is discarded, bytes unchanged.
// - Reading high byte re-enables result updates.
// - Complete flag still set for a discarded conversion.
// - Start bit begins a conversion, reads one until done, hardware clears.
// - Channel change during conversion applies only after it completes.
// - Auto trigger enable plus separate trigger select register.
// - Trigger rising edge resets prescaler and starts conversion.
// - Trigger still high at completion starts nothing new.
// - Trigger edge during conversion is ignored.
// - Flags used as trigger are set even when masked.
// - First conversion samples at 13.5, ends 25; auto samples 2, ends 13.5.
// - Normal single ended 1.5/13; differential 1.5 or 2.5 / 13 or 14.
// - Differential conversions after the first since enable aligned to half-rate converter clock phase.
// - Running auto conversion keeps previous channel, later ones new.
module acc_ctrl
	import acc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [NUM_TRIG-1:0] trigger_sources,
	input wire logic [RES_W-1:0] analog_code,
	output logic sample_strobe,
	output acc_sel_s active_sel,
	output logic converter_powered,
	output logic irq
);
	// Register state
	logic converter_enable;
	logic start_conversion_bit;
	logic auto_trigger_enable;
	logic complete_flag;
	logic complete_ie;
	logic [CTRL_PS_W-1:0] prescale_sel;
	acc_sel_s channel_reference_select;
	logic result_left_align;
	logic [TRIG_W-1:0] trigger_source_select;
	logic [RES_W-1:0] result;
	logic lock;
	logic first_done;
	logic trig_prev;
	logic [RES_W-1:0] held;
	// Conversion state
	acc_state_e state;
	acc_state_e next_state;
	logic [HALF_W-1:0] half_cnt;
	logic [HALF_W-1:0] next_half_cnt;
	logic [HALF_W-1:0] sample_at;
	logic [HALF_W-1:0] next_sample_at;
	logic [HALF_W-1:0] total_at;
	logic [HALF_W-1:0] next_total_at;
	logic [1:0] phase;
	// Bus state
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_go;
	logic rd_go;
	logic [31:0] rd_word;
	logic [1:0] rd_resp;
	logic [1:0] wr_resp;
	// Derived events
	logic half_tick;
	logic trig_now;
	logic trig_edge;
	logic start_sw;
	logic start_req;
	logic done;
	logic read_lo;
	logic read_hi;
	logic is_diff;

	acc_prescaler u_pre (
		.aclk(aclk),
		.aresetn(aresetn),
		.restart(start_req && auto_trigger_enable),
		.div_sel(prescale_sel),
		.half_tick(half_tick)
	);

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_go = aw_held && w_held && !s_axi_bvalid;
	assign rd_go = s_axi_arvalid && s_axi_arready;
	assign read_lo = rd_go && s_axi_araddr == ADDR_RES_LO;
	assign read_hi = rd_go && s_axi_araddr == ADDR_RES_HI;
	assign converter_powered = converter_enable;
	assign irq = complete_flag && complete_ie;
	assign trig_now = trigger_sources[trigger_source_select];
	assign trig_edge = trig_now && !trig_prev;
	assign start_sw = wr_go && aw_addr == ADDR_CTRL && w_strb[0] && w_data[CTRL_SC_BIT]
		&& w_data[CTRL_EN_BIT];
	// Edges arriving while busy are dropped, not queued
	assign start_req = converter_enable && state == ST_IDLE
		&& (start_sw || (auto_trigger_enable && trig_edge));
	assign done = state == ST_CONV && half_tick && half_cnt == total_at;
	assign is_diff = channel_reference_select.channel >= DIFF_CH_FIRST;

	// Read data mux
	always_comb begin
		rd_word = '0;
		rd_resp = RESP_OKAY;
		if (s_axi_araddr == ADDR_CTRL) begin
			rd_word[CTRL_EN_BIT] = converter_enable;
			rd_word[CTRL_SC_BIT] = start_conversion_bit;
			rd_word[CTRL_ATE_BIT] = auto_trigger_enable;
			rd_word[CTRL_IF_BIT] = complete_flag;
			rd_word[CTRL_IE_BIT] = complete_ie;
			rd_word[CTRL_PS_LSB +: CTRL_PS_W] = prescale_sel;
		end else if (s_axi_araddr == ADDR_MUX) begin
			rd_word[MUX_REF_LSB +: 2] = channel_reference_select.reference;
			rd_word[MUX_LAR_BIT] = result_left_align;
			rd_word[MUX_CH_LSB +: MUX_CH_W] = channel_reference_select.channel;
		end else if (s_axi_araddr == ADDR_TRIG) begin
			rd_word[TRIG_W-1:0] = trigger_source_select;
		end else if (s_axi_araddr == ADDR_RES_LO) begin
			rd_word[7:0] = result_left_align ? {result[1:0], 6'h00} : result[7:0];
		end else if (s_axi_araddr == ADDR_RES_HI) begin
			rd_word[7:0] = result_left_align ? result[9:2] : {6'h00, result[9:8]};
		end else begin
			rd_resp = RESP_SLVERR;
		end
		wr_resp = (aw_addr == ADDR_CTRL || aw_addr == ADDR_MUX || aw_addr == ADDR_TRIG)
			? RESP_OKAY : RESP_SLVERR;
	end

	// Conversion sequencer next state
	always_comb begin
		next_state = state;
		next_half_cnt = half_cnt;
		next_sample_at = sample_at;
		next_total_at = total_at;
		if (!converter_enable) begin
			next_state = ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: begin
					if (start_req) begin
						next_half_cnt = '0;
						if (!first_done) begin
							next_sample_at = HALF_W'(FIRST_SAMPLE_HALF);
							next_total_at = HALF_W'(FIRST_TOTAL_HALF);
						end else if (auto_trigger_enable && !start_sw) begin
							next_sample_at = HALF_W'(AUTO_SAMPLE_HALF);
							next_total_at = HALF_W'(AUTO_TOTAL_HALF);
						end else begin
							next_sample_at = HALF_W'(NORM_SAMPLE_HALF);
							next_total_at = HALF_W'(NORM_TOTAL_HALF);
						end
						next_state = (is_diff && first_done) ? ST_ALIGN : ST_CONV;
					end
				end
				ST_ALIGN: begin
					// Wait tick is the first conversion tick; one converter clock more if off phase
					if (half_tick) begin
						next_state = ST_CONV;
						next_half_cnt = HALF_W'(1);
						if (phase[1]) begin
							next_sample_at = sample_at + HALF_W'(DIFF_EXTRA_HALF);
							next_total_at = total_at + HALF_W'(DIFF_EXTRA_HALF);
						end
					end
				end
				ST_CONV: begin
					if (half_tick) begin
						next_half_cnt = half_cnt + HALF_W'(1);
					end
					if (done) begin
						next_state = ST_IDLE;
					end
				end
				default: next_state = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_IDLE;
			half_cnt <= '0;
			sample_at <= '0;
			total_at <= '0;
		end else begin
			state <= next_state;
			half_cnt <= next_half_cnt;
			sample_at <= next_sample_at;
			total_at <= next_total_at;
		end
	end

	// Registers, bus and result handling
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			converter_enable <= 1'b0;
			start_conversion_bit <= 1'b0;
			auto_trigger_enable <= 1'b0;
			complete_flag <= 1'b0;
			complete_ie <= 1'b0;
			prescale_sel <= '0;
			channel_reference_select <= '0;
			result_left_align <= 1'b0;
			trigger_source_select <= '0;
			active_sel <= '0;
			result <= '0;
			held <= '0;
			lock <= 1'b0;
			first_done <= 1'b0;
			trig_prev <= 1'b0;
			phase <= '0;
			sample_strobe <= 1'b0;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			trig_prev <= trig_now;
			sample_strobe <= 1'b0;
			if (half_tick) begin
				phase <= phase + 2'h1;
			end
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			if (wr_go) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_resp;
				if (aw_addr == ADDR_CTRL && w_strb[0]) begin
					converter_enable <= w_data[CTRL_EN_BIT];
					auto_trigger_enable <= w_data[CTRL_ATE_BIT];
					complete_ie <= w_data[CTRL_IE_BIT];
					prescale_sel <= w_data[CTRL_PS_LSB +: CTRL_PS_W];
					// Write one clears the flag; completion below wins
					if (w_data[CTRL_IF_BIT]) begin
						complete_flag <= 1'b0;
					end
					if (!w_data[CTRL_EN_BIT]) begin
						start_conversion_bit <= 1'b0;
						first_done <= 1'b0;
					end
				end else if (aw_addr == ADDR_MUX && w_strb[0]) begin
					channel_reference_select.reference <= w_data[MUX_REF_LSB +: 2];
					result_left_align <= w_data[MUX_LAR_BIT];
					channel_reference_select.channel <= w_data[MUX_CH_LSB +: MUX_CH_W];
				end else if (aw_addr == ADDR_TRIG && w_strb[0]) begin
					trigger_source_select <= w_data[TRIG_W-1:0];
				end
			end
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_resp;
			end
			if (read_lo) begin
				lock <= 1'b1;
			end
			if (read_hi) begin
				lock <= 1'b0;
			end
			if (converter_enable && !active_sel_busy(state)) begin
				// Selections pass on only while enabled and idle
				active_sel <= channel_reference_select;
			end
			if (start_req) begin
				start_conversion_bit <= 1'b1;
				active_sel <= channel_reference_select;
			end
			if (state == ST_CONV && half_tick && half_cnt == sample_at) begin
				sample_strobe <= 1'b1;
				held <= analog_code;
			end
			if (done) begin
				start_conversion_bit <= 1'b0;
				first_done <= 1'b1;
				complete_flag <= 1'b1;
				if (!lock || read_hi) begin
					result <= held;
				end
			end
		end
	end

	function automatic logic active_sel_busy(input acc_state_e st);
		active_sel_busy = st != ST_IDLE;
	endfunction
endmodule

// ---- acc_pkg.sv ----
// Package for the converter control block: register map, fields, timing counts
package acc_pkg;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_MUX = 8'h04;
	localparam logic [7:0] ADDR_TRIG = 8'h08;
	localparam logic [7:0] ADDR_RES_LO = 8'h0c;
	localparam logic [7:0] ADDR_RES_HI = 8'h10;
	localparam logic [7:0] ADDR_SAMPLE = 8'h14;
	// Control register fields
	localparam int CTRL_EN_BIT = 7;
	localparam int CTRL_SC_BIT = 6;
	localparam int CTRL_ATE_BIT = 5;
	localparam int CTRL_IF_BIT = 4;
	localparam int CTRL_IE_BIT = 3;
	localparam int CTRL_PS_LSB = 0;
	localparam int CTRL_PS_W = 3;
	// Channel/reference register fields
	localparam int MUX_REF_LSB = 6;
	localparam int MUX_LAR_BIT = 5;
	localparam int MUX_CH_LSB = 0;
	localparam int MUX_CH_W = 5;
	localparam int TRIG_W = 3;
	localparam int NUM_TRIG = 8;
	localparam int RES_W = 10;
	// Channel codes at or above this value are differential
	localparam logic [MUX_CH_W-1:0] DIFF_CH_FIRST = 5'h08;
	// Conversion timing in half converter clocks
	localparam int FIRST_SAMPLE_HALF = 27;
	localparam int FIRST_TOTAL_HALF = 50;
	localparam int AUTO_SAMPLE_HALF = 4;
	localparam int AUTO_TOTAL_HALF = 27;
	localparam int NORM_SAMPLE_HALF = 3;
	localparam int NORM_TOTAL_HALF = 26;
	localparam int DIFF_EXTRA_HALF = 2;
	localparam int HALF_W = 6;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ALIGN = 2'b01,
		ST_CONV = 2'b11
	} acc_state_e;
	typedef struct packed {
		logic [1:0] reference;
		logic [MUX_CH_W-1:0] channel;
	} acc_sel_s;
endpackage

// ---- acc_prescaler.sv ----
// Converter clock prescaler producing half-period enable pulses
`timescale 1ns/1ps
module acc_prescaler
	import acc_pkg::*;
#(
	parameter int DIV_W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic restart,
	input wire logic [CTRL_PS_W-1:0] div_sel,
	output logic half_tick
);
	logic [DIV_W-1:0] count;
	logic [DIV_W-1:0] next_count;
	logic [DIV_W-1:0] limit;

	// Half period of the converter clock is 2**div_sel system clocks
	always_comb begin
		limit = DIV_W'((1 << div_sel) - 1);
		half_tick = (count == limit) && !restart;
		if (restart || count == limit) begin
			next_count = '0;
		end else begin
			next_count = count + DIV_W'(1);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end
endmodule

// ---- acc_ctrl_asserts.sv ----
// Port checker for the converter control block
`timescale 1ns/1ps
module acc_ctrl_asserts
	import acc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic sample_strobe,
	input wire acc_sel_s active_sel,
	input wire logic converter_powered
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> !s_axi_awready ##1 s_axi_bvalid) else $error("write response late");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read response late");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	strobe_gap_a: assert property (sample_strobe |=> (!sample_strobe)[*8])
		else $error("sample pulses too close");
	strobe_power_a: assert property (sample_strobe |-> converter_powered)
		else $error("sample while disabled");
	sel_frozen_a: assert property (sample_strobe |-> $stable(active_sel))
		else $error("selection moved in conversion");
	sel_off_a: assert property (!converter_powered && !$past(converter_powered) |-> $stable(active_sel))
		else $error("selection applied while disabled");
endmodule

// ---- acc_front_model.sv ----
// Analog front end model: code built from the applied selection
`timescale 1ns/1ps
module acc_front_model
	import acc_pkg::*;
(
	input wire logic aclk,
	input wire acc_sel_s active_sel,
	input wire logic converter_powered,
	output logic [RES_W-1:0] analog_code
);
	logic [RES_W-1:0] noise = 10'h2aa;
	// Unpowered input shows a toggling pattern
	always @(posedge aclk) begin
		noise <= ~noise;
	end
	assign analog_code = converter_powered ? {active_sel.reference, active_sel.channel, 3'h5} : noise;
endmodule

// ---- testbench.sv ----
// Testbench for the converter control block
`timescale 1ns/1ps
module testbench
	import acc_pkg::*;
;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready = 1'b0;
	logic [7:0] s_axi_araddr = 8'h00;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready = 1'b0;
	logic [NUM_TRIG-1:0] trigger_sources = 8'h00;
	logic [RES_W-1:0] analog_code;
	logic sample_strobe;
	acc_sel_s active_sel;
	logic converter_powered;
	logic irq;
	int miscompares = 0;
	int comparisons = 0;
	int strobes = 0;
	int cyc = 0;
	int t_strobe = 0;
	int t0, d1, d2, d3, s0;
	acc_ctrl u_dut (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .trigger_sources, .analog_code, .sample_strobe, .active_sel,
		.converter_powered, .irq
	);
	acc_front_model u_front (.aclk, .active_sel, .converter_powered, .analog_code);
	initial begin
		forever #5 aclk = ~aclk;
	end
	// Cycle stamp of the latest sample point
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (sample_strobe === 1'b1) begin
			strobes <= strobes + 1;
			t_strobe <= cyc;
		end
	end
	task automatic final_report();
		$display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tmo(input int n);
		if (n >= 300) begin
			chk(32'h0, 32'h1);
			final_report();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) s_axi_bready <= !s_axi_bready;
		end while (!(s_axi_bvalid && s_axi_bready) && n < 300);
		tmo(n);
		chk(32'(s_axi_bresp), 32'(er));
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
		input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) s_axi_rready <= !s_axi_rready;
		end while (!(s_axi_rvalid && s_axi_rready) && n < 300);
		tmo(n);
		chk(s_axi_rdata & m, e);
		chk(32'(s_axi_rresp), 32'(er));
	endtask
	task automatic wirq();
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 300) begin
			@(posedge aclk);
			n++;
		end
		tmo(n);
	endtask
	task automatic trig(input logic [7:0] v, input int c);
		@(posedge aclk);
		trigger_sources <= v;
		repeat (c) @(posedge aclk);
	endtask
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rc(ADDR_CTRL, 32'hff, 32'h00, RESP_OKAY);
		rc(8'h18, 32'h0, 32'h0, RESP_SLVERR);
		wr(ADDR_RES_LO, 32'h55, RESP_SLVERR);
		wr(ADDR_MUX, 32'h43, RESP_OKAY);
		@(posedge aclk);
		chk(32'(active_sel), 32'h00);
		chk(32'(converter_powered), 32'h0);
		wr(ADDR_CTRL, 32'h80, RESP_OKAY);
		@(posedge aclk);
		chk(32'(active_sel), 32'h23);
		chk(32'(converter_powered), 32'h1);
		wr(ADDR_CTRL, 32'hc8, RESP_OKAY);
		t0 = cyc;
		wr(ADDR_MUX, 32'h84, RESP_OKAY);
		rc(ADDR_CTRL, 32'h40, 32'h40, RESP_OKAY);
		wirq();
		d1 = t_strobe - t0;
		rc(ADDR_CTRL, 32'h50, 32'h10, RESP_OKAY);
		rc(ADDR_RES_LO, 32'hff, 32'h1d, RESP_OKAY);
		wr(ADDR_CTRL, 32'hd8, RESP_OKAY);
		t0 = cyc;
		wirq();
		d2 = t_strobe - t0;
		rc(ADDR_RES_HI, 32'hff, 32'h01, RESP_OKAY);
		rc(ADDR_RES_LO, 32'hff, 32'h1d, RESP_OKAY);
		rc(ADDR_RES_HI, 32'hff, 32'h01, RESP_OKAY);
		wr(ADDR_MUX, 32'ha4, RESP_OKAY);
		wr(ADDR_CTRL, 32'hd8, RESP_OKAY);
		wirq();
		rc(ADDR_RES_HI, 32'hff, 32'h89, RESP_OKAY);
		wr(ADDR_MUX, 32'h88, RESP_OKAY);
		wr(ADDR_CTRL, 32'hd8, RESP_OKAY);
		t0 = cyc;
		wirq();
		d3 = t_strobe - t0;
		chk(32'(d1 - d2), 32'd24);
		chk(32'((d3 - d2) inside {0, 2}), 32'h1);
		wr(ADDR_CTRL, 32'h90, RESP_OKAY);
		wr(ADDR_TRIG, 32'h03, RESP_OKAY);
		wr(ADDR_CTRL, 32'ha0, RESP_OKAY);
		s0 = strobes;
		trig(8'h04, 60);
		chk(strobes - s0, 32'd0);
		trig(8'h0c, 8);
		trig(8'h04, 2);
		trig(8'h0c, 80);
		chk(strobes - s0, 32'd1);
		chk(32'(irq), 32'h0);
		rc(ADDR_CTRL, 32'h10, 32'h10, RESP_OKAY);
		wr(ADDR_CTRL, 32'hb0, RESP_OKAY);
		trig(8'h04, 2);
		trig(8'h0c, 60);
		chk(strobes - s0, 32'd2);
		final_report();
	end
endmodule
bind acc_ctrl acc_ctrl_asserts u_chk (
	.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready, .s_axi_rdata, .sample_strobe, .active_sel, .converter_powered
);
